// [logic/power_event_pkg.sv]
// Overview of operation
// - The event pin has three setups: nothing routed, one or more alarms routed, or a manual software level.
// - Any mix of sag, surge, over current and over power alarms may be routed, and the pin is high while any routed alarm is active.
// - Over current and over power conditions are taken once per finished computation cycle of the calculation engine.
// - Sag and surge use a faster path than the per-computation-cycle alarms so their interrupt comes with little delay.
// - Sag and surge have no hold register, since their detection finishes inside one line cycle.
// - A trailing mean square of the line voltage is kept up to date for the sag and surge comparators.
// - On every data-ready strobe the trailing mean square is checked against both the sag limit and the surge limit.
// - A routed sag or surge alarm whose flag is set drives the event pin high.
// - Bits 31 to 20 and bits 15, 13 and 12 of the event configuration register ignore writes and read zero.
// - Routing bits 19, 18, 17 and 16 send over power, over current, surge and sag to the pin when set.
// - Latch bits 7, 6, 5 and 4 make surge, sag, over power and over current hold until cleared, else they follow the condition.
// - Writing one to bit 11, 10, 9 or 8 clears the real or simulated over current, over power, surge or sag alarm, and the bit reads zero after.
// - Test bits 3, 2, 1 and 0 force a simulated surge, sag, over power or over current alarm while set.
package power_event_pkg;

    // Register geometry
    localparam int          CFG_W          = 32;
    localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
    // Bits that hold a written value; clear bits are strobes and never stored
    localparam logic [31:0] CFG_STORE_MASK = 32'h000F_40FF;

    // Alarm indices used for every per-alarm vector
    localparam int NUM_ALARMS    = 4;
    localparam int ALARM_CURRENT = 0;
    localparam int ALARM_POWER   = 1;
    localparam int ALARM_SAG     = 2;
    localparam int ALARM_SURGE   = 3;

    // Field positions per alarm, in alarm index order
    localparam int ROUTE_POS [0:3] = '{18, 19, 16, 17};
    localparam int CLEAR_POS [0:3] = '{11, 10, 8, 9};
    localparam int LATCH_POS [0:3] = '{4, 5, 6, 7};
    localparam int TEST_POS  [0:3] = '{0, 1, 2, 3};
    localparam int MANUAL_POS      = 14;

    // Voltage path defaults
    localparam int SAMPLE_W     = 16;
    localparam int AVG_SHIFT    = 4;

    // Pin configurations
    typedef enum logic [1:0] {
        PIN_IDLE,
        PIN_ROUTED,
        PIN_MANUAL
    } pin_mode_t;

endpackage

// [logic/voltage_mean_square_compare.sv]
module voltage_mean_square_compare
    import power_event_pkg::*;
#(
    parameter int SAMPLE_WIDTH = power_event_pkg::SAMPLE_W,
    parameter int SHIFT        = power_event_pkg::AVG_SHIFT
)
(
    // Clock and reset
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rst_n,
    // Voltage samples
    input  wire logic                      i_data_ready,
    input  wire logic [SAMPLE_WIDTH-1:0]   i_voltage_sample,
    // Limits
    input  wire logic [2*SAMPLE_WIDTH-1:0] i_sag_limit,
    input  wire logic [2*SAMPLE_WIDTH-1:0] i_surge_limit,
    // Results
    output logic [2*SAMPLE_WIDTH-1:0]      o_trailing_voltage_mean_square,
    output logic                           o_sag_cond,
    output logic                           o_surge_cond
);

    localparam int MS_W = 2 * SAMPLE_WIDTH;

    typedef struct packed {
        logic [MS_W-1:0] mean_sq;
        logic            sag;
        logic            surge;
    } ms_state_t;

    ms_state_t                st;
    ms_state_t                next_st;
    logic signed [MS_W-1:0]   sample_sq;
    logic        [MS_W-1:0]   new_ms;

    // Exponential trailing average; it can never overflow since it is a convex mix
    always_comb
    begin
        next_st   = st;
        sample_sq = $signed(i_voltage_sample) * $signed(i_voltage_sample);
        new_ms    = st.mean_sq - (st.mean_sq >> SHIFT) + (MS_W'(sample_sq) >> SHIFT);
        if (i_data_ready)
        begin
            next_st.mean_sq = new_ms;
            next_st.sag     = (new_ms < i_sag_limit);
            next_st.surge   = (new_ms > i_surge_limit);
        end
    end

    // State register
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign o_trailing_voltage_mean_square = st.mean_sq;
    assign o_sag_cond                     = st.sag;
    assign o_surge_cond                   = st.surge;

endmodule

// [logic/power_event_pin_logic.sv]
module power_event_pin_logic
#(
    parameter int SAMPLE_WIDTH = power_event_pkg::SAMPLE_W,
    parameter int SHIFT        = power_event_pkg::AVG_SHIFT
)
(
    // Clock and reset
    input  wire logic                                  i_core_clk,
    input  wire logic                                  i_arst_n,
    // Event configuration register access
    input  wire logic                                  i_cfg_wr,
    input  wire logic [power_event_pkg::CFG_W-1:0]     i_cfg_wdata,
    output logic      [power_event_pkg::CFG_W-1:0]     o_cfg_rdata,
    // Voltage path
    input  wire logic                                  i_data_ready,
    input  wire logic [SAMPLE_WIDTH-1:0]               i_voltage_sample,
    input  wire logic [2*SAMPLE_WIDTH-1:0]             i_sag_limit,
    input  wire logic [2*SAMPLE_WIDTH-1:0]             i_surge_limit,
    // Computation cycle results
    input  wire logic                                  i_cycle_done,
    input  wire logic                                  i_over_current,
    input  wire logic                                  i_over_power,
    // Event outputs
    output logic                                       o_event_pin,
    output logic      [power_event_pkg::NUM_ALARMS-1:0] o_alarm_flags,
    output logic      [2*SAMPLE_WIDTH-1:0]             o_trailing_voltage_mean_square
);

    import power_event_pkg::*;

    typedef struct packed {
        logic [CFG_W-1:0]      cfg;
        logic [1:0]            slow_cond;
        logic [NUM_ALARMS-1:0] flag;
        pin_mode_t             mode;
        logic                  pin;
    } event_state_t;

    event_state_t          st;
    event_state_t          next_st;
    logic                  rst_meta_n;
    logic                  rst_n;
    logic                  sag_cond;
    logic                  surge_cond;
    logic [NUM_ALARMS-1:0] cond;
    logic [NUM_ALARMS-1:0] clear_req;
    logic [NUM_ALARMS-1:0] active;
    logic [NUM_ALARMS-1:0] latched;
    logic [NUM_ALARMS-1:0] routed;
    logic [NUM_ALARMS-1:0] simulated;
    logic [NUM_ALARMS-1:0] next_flag;
    logic [CFG_W-1:0]      next_cfg;

    // Named routing fields
    logic                  route_power_alarm;
    logic                  route_current_alarm;
    logic                  route_high_voltage_alarm;
    logic                  route_low_voltage_alarm;

    // Named manual level
    logic                  manual_output_level;

    // Named clear strobes
    logic                  clear_current_alarm;
    logic                  clear_power_alarm;
    logic                  clear_high_voltage_alarm;
    logic                  clear_low_voltage_alarm;

    // Named latch enables
    logic                  latch_high_voltage_alarm;
    logic                  latch_low_voltage_alarm;
    logic                  latch_power_alarm;
    logic                  latch_current_alarm;

    // Named test forces
    logic                  simulate_high_voltage_alarm;
    logic                  simulate_low_voltage_alarm;
    logic                  simulate_power_alarm;
    logic                  simulate_current_alarm;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // Fast voltage path, refreshed on every data-ready strobe
    voltage_mean_square_compare #(
        .SAMPLE_WIDTH (SAMPLE_WIDTH),
        .SHIFT        (SHIFT)
    ) u_voltage (
        .i_core_clk                     (i_core_clk),
        .i_rst_n                        (rst_n),
        .i_data_ready                   (i_data_ready),
        .i_voltage_sample               (i_voltage_sample),
        .i_sag_limit                    (i_sag_limit),
        .i_surge_limit                  (i_surge_limit),
        .o_trailing_voltage_mean_square (o_trailing_voltage_mean_square),
        .o_sag_cond                     (sag_cond),
        .o_surge_cond                   (surge_cond)
    );

    // New configuration: unimplemented and clear bits never stored, and a clear also drops the test bit
    always_comb
    begin
        next_cfg = st.cfg;
        if (i_cfg_wr)
        begin
            next_cfg = i_cfg_wdata & CFG_STORE_MASK;
            for (int k = 0; k < NUM_ALARMS; k++)
            begin
                if (i_cfg_wdata[CLEAR_POS[k]])
                    next_cfg[TEST_POS[k]] = 1'b0;
            end
        end
    end

    // Raw conditions; sag and surge come straight from the comparator with no hold copy
    assign cond[ALARM_CURRENT] = st.slow_cond[0];
    assign cond[ALARM_POWER]   = st.slow_cond[1];
    assign cond[ALARM_SAG]     = sag_cond;
    assign cond[ALARM_SURGE]   = surge_cond;

    // Routing fields of the new word, so a write retargets the pin on its own edge
    assign route_current_alarm      = next_cfg[ROUTE_POS[ALARM_CURRENT]];
    assign route_power_alarm        = next_cfg[ROUTE_POS[ALARM_POWER]];
    assign route_low_voltage_alarm  = next_cfg[ROUTE_POS[ALARM_SAG]];
    assign route_high_voltage_alarm = next_cfg[ROUTE_POS[ALARM_SURGE]];

    // Manual level only counts while nothing is routed
    assign manual_output_level      = next_cfg[MANUAL_POS];

    // Clear strobes act in the write cycle only and are never stored
    assign clear_current_alarm      = i_cfg_wr & i_cfg_wdata[CLEAR_POS[ALARM_CURRENT]];
    assign clear_power_alarm        = i_cfg_wr & i_cfg_wdata[CLEAR_POS[ALARM_POWER]];
    assign clear_low_voltage_alarm  = i_cfg_wr & i_cfg_wdata[CLEAR_POS[ALARM_SAG]];
    assign clear_high_voltage_alarm = i_cfg_wr & i_cfg_wdata[CLEAR_POS[ALARM_SURGE]];

    // Latch fields from the new word too, so a latch change and the flags move on one edge
    assign latch_current_alarm      = next_cfg[LATCH_POS[ALARM_CURRENT]];
    assign latch_power_alarm        = next_cfg[LATCH_POS[ALARM_POWER]];
    assign latch_low_voltage_alarm  = next_cfg[LATCH_POS[ALARM_SAG]];
    assign latch_high_voltage_alarm = next_cfg[LATCH_POS[ALARM_SURGE]];

    // Test fields force a simulated cause while they stand
    assign simulate_current_alarm      = next_cfg[TEST_POS[ALARM_CURRENT]];
    assign simulate_power_alarm        = next_cfg[TEST_POS[ALARM_POWER]];
    assign simulate_low_voltage_alarm  = next_cfg[TEST_POS[ALARM_SAG]];
    assign simulate_high_voltage_alarm = next_cfg[TEST_POS[ALARM_SURGE]];

    // Gather the named fields into alarm index order
    // Order is surge, sag, over power, over current from the top bit down
    assign routed    = {route_high_voltage_alarm, route_low_voltage_alarm,
                        route_power_alarm, route_current_alarm};
    assign latched   = {latch_high_voltage_alarm, latch_low_voltage_alarm,
                        latch_power_alarm, latch_current_alarm};
    assign simulated = {simulate_high_voltage_alarm, simulate_low_voltage_alarm,
                        simulate_power_alarm, simulate_current_alarm};
    assign clear_req = {clear_high_voltage_alarm, clear_low_voltage_alarm,
                        clear_power_alarm, clear_current_alarm};

    // Per-alarm flag logic; a new event wins over a clear in the same cycle
    // Non-latched flags ignore a clear, they simply follow their cause
    for (genvar g = 0; g < NUM_ALARMS; g++)
    begin : g_alarm
        assign active[g]    = cond[g] | simulated[g];
        assign next_flag[g] = latched[g] ? (active[g] | (st.flag[g] & ~clear_req[g]))
                                         : active[g];
    end

    // Next state
    always_comb
    begin
        next_st      = st;
        next_st.cfg  = next_cfg;
        next_st.flag = next_flag;
        // Slow alarms only move at the end of a computation cycle
        if (i_cycle_done)
        begin
            next_st.slow_cond[0] = i_over_current;
            next_st.slow_cond[1] = i_over_power;
        end
        // Pin setup follows the routing bits of the new word
        // Manual level is ignored while anything is routed, so a stale level cannot mask an alarm
        if (|routed)
            next_st.mode = PIN_ROUTED;
        else if (manual_output_level)
            next_st.mode = PIN_MANUAL;
        else
            next_st.mode = PIN_IDLE;
        unique case (next_st.mode)
            PIN_ROUTED:
                next_st.pin = |(next_flag & routed);
            PIN_MANUAL:
                next_st.pin = 1'b1;
            PIN_IDLE:
                next_st.pin = 1'b0;
        endcase
    end

    // State register; everything clears at reset
    always_ff @(posedge i_core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st      <= '0;
            st.cfg  <= CFG_RESET;
            st.mode <= PIN_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    assign o_cfg_rdata   = st.cfg;
    assign o_event_pin   = st.pin;
    assign o_alarm_flags = st.flag;

endmodule

// [tb/power_event_pin_logic_sva.sv]
module power_event_pin_logic_sva
#(
    parameter int SAMPLE_WIDTH = 16
)
(
    // Watched ports
    input wire logic                      i_core_clk,
    input wire logic                      i_arst_n,
    input wire logic                      i_cfg_wr,
    input wire logic [31:0]               i_cfg_wdata,
    input wire logic [31:0]               o_cfg_rdata,
    input wire logic                      i_data_ready,
    input wire logic [2*SAMPLE_WIDTH-1:0] i_sag_limit,
    input wire logic [2*SAMPLE_WIDTH-1:0] i_surge_limit,
    input wire logic                      i_cycle_done,
    input wire logic                      o_event_pin,
    input wire logic [3:0]                o_alarm_flags,
    input wire logic [2*SAMPLE_WIDTH-1:0] o_trailing_voltage_mean_square
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_arst_n);

    // Routing bits rearranged into flag order, so pin logic compares bit for bit
    wire logic [3:0] routed = {o_cfg_rdata[17], o_cfg_rdata[16], o_cfg_rdata[19], o_cfg_rdata[18]};

    // Register storage and pin mapping
    property p_unused; (o_cfg_rdata & 32'hFFF0_BF00) == 32'h0; endproperty
    property p_store; i_cfg_wr |=> (o_cfg_rdata & 32'h000F_40F0) == ($past(i_cfg_wdata) & 32'h000F_40F0); endproperty
    property p_pin; |o_cfg_rdata[19:16] |-> o_event_pin == |(o_alarm_flags & routed); endproperty
    property p_manual; o_cfg_rdata[19:16] == 4'h0 |-> o_event_pin == o_cfg_rdata[14]; endproperty
    property p_test; (o_cfg_rdata[3:0] & ~o_alarm_flags) == 4'h0; endproperty
    // Alarm timing: slow alarms move only after a cycle end, fast ones after data ready
    property p_slow; $changed(o_alarm_flags[1:0]) |-> $past(i_cycle_done, 2) || $past(i_cfg_wr); endproperty
    property p_fast; $changed(o_alarm_flags[3:2]) |-> $past(i_data_ready, 2) || $past(i_cfg_wr); endproperty
    property p_sag; i_data_ready ##1 (o_trailing_voltage_mean_square < i_sag_limit) |=> o_alarm_flags[2]; endproperty
    property p_surge; i_data_ready ##1 (o_trailing_voltage_mean_square > i_surge_limit) |=> o_alarm_flags[3]; endproperty
    property p_latch; o_alarm_flags[2] && o_cfg_rdata[6] && !i_cfg_wr |=> o_alarm_flags[2]; endproperty

    a_unused: assert property (p_unused) else $error("unused bits not zero");
    a_store: assert property (p_store) else $error("stored fields wrong");
    a_pin: assert property (p_pin) else $error("routed pin wrong");
    a_manual: assert property (p_manual) else $error("manual pin wrong");
    a_test: assert property (p_test) else $error("simulated alarm missing");
    a_slow: assert property (p_slow) else $error("slow flag moved early");
    a_fast: assert property (p_fast) else $error("fast flag moved off strobe");
    a_sag: assert property (p_sag) else $error("sag flag not set");
    a_surge: assert property (p_surge) else $error("surge flag not set");
    a_latch: assert property (p_latch) else $error("latched flag dropped");

    c_sag: cover property (i_data_ready ##2 o_alarm_flags[2]);
    c_slow: cover property (i_cycle_done ##2 o_alarm_flags[0]);
    c_manual: cover property (o_event_pin && o_cfg_rdata[14]);
endmodule

// [tb/host_irq_model.sv]
module host_irq_model
(
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_arst_n,
    // Interrupt line and its rising-edge count
    input  wire logic       i_irq,
    output logic      [7:0] o_irq_count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev;

    // Edge counting, as an edge-triggered host input would see the pin
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            prev        <= 1'b0;
            o_irq_count <= 8'h00;
        end
        else
        begin
            prev <= i_irq;
            if (i_irq && !prev)
                o_irq_count <= o_irq_count + 8'h01;
        end
    end
endmodule

// [tb/power_event_pin_logic_tb_top.sv]
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end
module power_event_pin_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct { logic [31:0] w; logic [31:0] r; logic [3:0] f; logic p; } row_t;
    logic        clk = 0, arst_n = 0, wr = 0, dr = 0, done = 0, ocur = 0, opow = 0, pin;
    logic [31:0] wdata = 0, rdata, sag_lim = 0, surge_lim = 32'hFFFF_FFFF, ms;
    logic [15:0] sample = 0;
    logic [3:0]  flags;
    logic [7:0]  irqs;
    int          miscompares = 0, n_tests = 0, cycles = 0;
    // Ordinary cases: written word, readback, flags, pin, with every condition idle
    row_t rows [11] = '{'{32'hFFFF_FFFF, 32'h000F_40F0, 4'h0, 0}, '{32'h0000_4000, 32'h0000_4000, 4'h0, 1},
        '{32'h0, 32'h0, 4'h0, 0}, '{32'h0001_0004, 32'h0001_0004, 4'h4, 1}, '{32'h0002_0008, 32'h0002_0008, 4'h8, 1},
        '{32'h0004_0001, 32'h0004_0001, 4'h1, 1}, '{32'h0008_0002, 32'h0008_0002, 4'h2, 1},
        '{32'h0004_0004, 32'h0004_0004, 4'h4, 0}, '{32'h0001_4000, 32'h0001_4000, 4'h0, 0},
        '{32'h0000_4001, 32'h0000_4001, 4'h1, 1}, '{32'h000F_000F, 32'h000F_000F, 4'hF, 1}};

    power_event_pin_logic dut (.i_core_clk(clk), .i_arst_n(arst_n), .i_cfg_wr(wr), .i_cfg_wdata(wdata),
        .o_cfg_rdata(rdata), .i_data_ready(dr), .i_voltage_sample(sample), .i_sag_limit(sag_lim),
        .i_surge_limit(surge_lim), .i_cycle_done(done), .i_over_current(ocur), .i_over_power(opow),
        .o_event_pin(pin), .o_alarm_flags(flags), .o_trailing_voltage_mean_square(ms));
    host_irq_model host (.i_core_clk(clk), .i_arst_n(arst_n), .i_irq(pin), .o_irq_count(irqs));

    // Clock and hang guard
    initial forever #25 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One-cycle strobes; outputs of the taking edge are settled on return
    task automatic write(input logic [31:0] w);
        @(negedge clk) wr = 1;
        wdata = w;
        @(negedge clk) wr = 0;
    endtask
    task automatic cycle_end(input logic c, input logic p, input logic [3:0] f);
        @(negedge clk) ocur = c;
        opow = p;
        done = 1;
        @(negedge clk) done = 0;
        @(negedge clk);
        `CHK(flags, f)
    endtask
    task automatic voltage(input logic [15:0] s, input logic [31:0] e, input logic [3:0] f);
        @(negedge clk) dr = 1;
        sample = s;
        @(negedge clk) dr = 0;
        `CHK(ms, e)
        @(negedge clk);
        `CHK(flags, f)
        `CHK(pin, 1'b1)
    endtask

    initial
    begin
        repeat (20) @(negedge clk);
        arst_n = 1;
        repeat (3) @(negedge clk);
        `CHK(rdata, 32'h0)
        `CHK({flags, pin}, 5'h0)
        foreach (rows[i])
        begin
            write(rows[i].w);
            `CHK(rdata, rows[i].r)
            `CHK(flags, rows[i].f)
            `CHK(pin, rows[i].p)
        end
        // Latched sag held after its test bit drops, then cleared by strobe
        write(32'h0000_0044);
        write(32'h0000_0040);
        `CHK(flags, 4'h4)
        write(32'h0000_0140);
        `CHK(rdata, 32'h0000_0040)
        `CHK(flags, 4'h0)
        // Raw slow conditions count only at a cycle end
        @(negedge clk) ocur = 1;
        opow = 1;
        repeat (3) @(negedge clk);
        `CHK(flags, 4'h0)
        cycle_end(1, 0, 4'h1);
        cycle_end(0, 1, 4'h2);
        cycle_end(0, 0, 4'h0);
        // Sag then surge through the mean square path
        write(32'h0003_0000);
        @(negedge clk) sag_lim = 32'h0000_1000;
        surge_lim = 32'h0080_0000;
        voltage(16'h0000, 32'h0, 4'h4);
        voltage(16'h4000, 32'h0100_0000, 4'h8);
        voltage(16'h4000, 32'h01F0_0000, 4'h8);
        `CHK(irqs, 8'h04)
        // Set wins: a clear of the latched surge is lost while its cause still stands
        write(32'h0003_0080);
        write(32'h0003_0280);
        `CHK(rdata, 32'h0003_0080)
        `CHK(flags, 4'h8)
        // Reset in mid-run clears everything, then the block works again
        @(negedge clk) arst_n = 0;
        @(negedge clk);
        `CHK(rdata, 32'h0)
        `CHK(ms, 32'h0)
        `CHK({flags, pin, irqs}, 13'h0)
        arst_n = 1;
        repeat (3) @(negedge clk);
        `CHK({flags, pin}, 5'h0)
        write(32'h0000_4000);
        `CHK(pin, 1'b1)
        end_of_test();
    end
endmodule
bind power_event_pin_logic power_event_pin_logic_sva #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) u_sva (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_cfg_wr(i_cfg_wr), .i_cfg_wdata(i_cfg_wdata),
    .o_cfg_rdata(o_cfg_rdata), .i_data_ready(i_data_ready), .i_sag_limit(i_sag_limit),
    .i_surge_limit(i_surge_limit), .i_cycle_done(i_cycle_done), .o_event_pin(o_event_pin),
    .o_alarm_flags(o_alarm_flags), .o_trailing_voltage_mean_square(o_trailing_voltage_mean_square));
